// ---- core/hfcs_pkg.sv ----
// How it works
// - FIFO port bytes are eight bits, bit 7 the packet byte MSB.
// - Transmit status empty bit shows live FIFO emptiness, never latched.
// - Transmit status full bit shows live FIFO fullness, never latched.
// - FIFO running dry inside a message sends an abort and sets underrun.
// - Underrun stays set until the host reads transmit status.
// - Source override 0 takes Sa choice from control two bits 3 to 7.
// - Sa/channel choice 0 routes the selected Sa bits to the receiver.
// - In Sa mode select bits 4 down to 0 enable Sa4 to Sa8.
// - Sa/channel choice 1 with source override 1 feeds channel data instead of Sa bits.
// - Channel mode with selection mode 0 picks one channel by number.
// - Channel mode with selection mode 1 takes channels from block registers.
// - Channel number bit 4 is MSB, bit 0 is LSB.
// - Each set suppress bit drops the matching channel bit, bit 7 the MSB.
// - Receive info register shows a live receive FIFO empty flag.
package hfcs_pkg;
  localparam int AW = 10;
  localparam int FIFO_DEPTH = 64;
  localparam int BYTE_W = 8;
  localparam int CH_W = 5;
  localparam int IRQ_W = 3;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_RX_INFO = 8'hb3;
  localparam logic [7:0] IDX_RX_PORT = 8'hb4;
  localparam logic [7:0] IDX_TX_STAT = 8'hb6;
  localparam logic [7:0] IDX_TX_PORT = 8'hb7;
  localparam logic [7:0] IDX_RX_SRC = 8'hb8;
  localparam logic [7:0] IDX_RX_SUP = 8'hb9;
  localparam logic [7:0] IDX_CTL_TWO = 8'hc0;
  localparam logic [7:0] IDX_CHBLK = 8'hc1;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hc4;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hc5;
  // field positions
  localparam int SRC_OVR_BIT = 7;
  localparam int SA_DS0_BIT = 6;
  localparam int MODE_BIT = 5;
  localparam int CTL_TWO_SA_LSB = 3;
  localparam int TX_EMPTY_BIT = 2;
  localparam int TX_FULL_BIT = 1;
  localparam int TX_UDR_BIT = 0;
  localparam int RX_EMPTY_BIT = 3;
  localparam int IRQ_UDR = 0;
  localparam int IRQ_RX_AVAIL = 1;
  localparam int IRQ_TX_EMPTY = 2;
  // reset values
  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_SUP = 8'h00;
  localparam logic [7:0] RST_CTL_TWO = 8'h00;
  localparam logic [31:0] RST_CHBLK = 32'h0;
  localparam logic [IRQ_W-1:0] RST_MASK = 3'h0;
  // sa bits live in timeslot zero of the non-alignment frame
  localparam logic [CH_W-1:0] SA_TS = 5'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- core/hfcs_fifo.sv ----
`timescale 1ns/1ns
module hfcs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // live flags
  output logic empty,
  output logic full
);
  // depth must be a power of two: pointers wrap with one extra lap bit
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign empty = (wp_r == rp_r);
  assign full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage needs no reset, the pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[PW-1:0]] <= in_data;
    end
  end
endmodule

// ---- core/hfcs_top.sv ----
`timescale 1ns/1ns
module hfcs_top
  import hfcs_pkg::*;
#(
  parameter int DEPTH = hfcs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // axi4-lite write address and data
  input wire logic [hfcs_pkg::AW-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [hfcs_pkg::AW-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // receive timeslot stream from the framer
  input wire logic [7:0] RX_TS_DATA,
  input wire logic [hfcs_pkg::CH_W-1:0] RX_TS_NUM,
  input wire logic RX_TS_NFAS,
  input wire logic RX_TS_STB,
  // selected bits toward the receive hdlc engine
  output logic [7:0] RX_HDLC_DATA,
  output logic [7:0] RX_HDLC_EN,
  output logic RX_HDLC_STB,
  // bytes from the receive hdlc engine
  input wire logic [7:0] RX_FIFO_WDATA,
  input wire logic RX_FIFO_WVALID,
  output logic RX_FIFO_WREADY,
  // bytes toward the transmit hdlc engine
  output logic [7:0] TX_FIFO_RDATA,
  output logic TX_FIFO_RVALID,
  input wire logic TX_FIFO_RREADY,
  input wire logic TX_IN_MSG,
  output logic TX_ABORT,
  // interrupt
  output logic IRQ
);
  import hfcs_pkg::*;

  // ==========================================
  // fifos
  logic tx_push, tx_empty, tx_full, rx_pop, rx_empty;
  logic [7:0] wd8, rx_head;

  hfcs_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(MCLK),
    .rst_n(ARST_N),
    .in_data(wd8),
    .in_valid(tx_push),
    .in_ready(),
    .out_data(TX_FIFO_RDATA),
    .out_valid(TX_FIFO_RVALID),
    .out_ready(TX_FIFO_RREADY),
    .empty(tx_empty),
    .full(tx_full)
  );
  hfcs_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(MCLK),
    .rst_n(ARST_N),
    .in_data(RX_FIFO_WDATA),
    .in_valid(RX_FIFO_WVALID),
    .in_ready(RX_FIFO_WREADY),
    .out_data(rx_head),
    .out_valid(),
    .out_ready(rx_pop),
    .empty(rx_empty),
    .full()
  );

  // ==========================================
  // axi4-lite write channel
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt, waddr;
  logic [31:0] wdata_r, wdata_nxt, wd;
  logic [3:0] wstrb_r, wstrb_nxt, wst;
  logic aw_ok, w_ok, wr_go, whit;
  logic [7:0] widx;
  assign AWREADY = !aw_have_r && !bvalid_r;
  assign WREADY = !w_have_r && !bvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign aw_ok = aw_have_r || (AWVALID && AWREADY);
  assign w_ok = w_have_r || (WVALID && WREADY);
  assign wr_go = aw_ok && w_ok;
  assign waddr = aw_have_r ? awaddr_r : AWADDR;
  assign wd = w_have_r ? wdata_r : WDATA;
  assign wst = w_have_r ? wstrb_r : WSTRB;
  assign widx = waddr[9:2];
  assign wd8 = wd[7:0];
  always_comb begin
    case (widx)
      IDX_RX_INFO, IDX_RX_PORT, IDX_TX_STAT, IDX_TX_PORT, IDX_RX_SRC,
      IDX_RX_SUP, IDX_CTL_TWO, IDX_CHBLK, IDX_IRQ_STAT, IDX_IRQ_MASK: whit = 1'b1;
      default: whit = 1'b0;
    endcase
    aw_have_nxt = wr_go ? 1'b0 : aw_ok;
    w_have_nxt = wr_go ? 1'b0 : w_ok;
    awaddr_nxt = (AWVALID && AWREADY) ? AWADDR : awaddr_r;
    wdata_nxt = (WVALID && WREADY) ? WDATA : wdata_r;
    wstrb_nxt = (WVALID && WREADY) ? WSTRB : wstrb_r;
    bvalid_nxt = wr_go || (bvalid_r && !BREADY);
    bresp_nxt = wr_go ? (whit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // a write to a full fifo is dropped, the fifo refuses it
  assign tx_push = wr_go && (widx == IDX_TX_PORT) && wst[0];

  // ==========================================
  // control registers and interrupts
  logic [7:0] src_r, src_nxt, sup_r, sup_nxt, ctl2_r, ctl2_nxt;
  logic [31:0] chblk_r, chblk_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, w1c, evt;
  logic udr_r, udr_nxt, abort_r, abort_nxt, tx_empty_q, udr_evt, stat_rd;
  // underrun only counts while the engine is inside a message
  assign udr_evt = TX_FIFO_RREADY && tx_empty && TX_IN_MSG;
  assign w1c = (wr_go && widx == IDX_IRQ_STAT && wst[0]) ? wd[IRQ_W-1:0] : '0;
  assign evt = {tx_empty && !tx_empty_q, RX_FIFO_WVALID && RX_FIFO_WREADY, udr_evt};
  always_comb begin
    src_nxt = src_r;
    sup_nxt = sup_r;
    ctl2_nxt = ctl2_r;
    imask_nxt = imask_r;
    chblk_nxt = chblk_r;
    if (wr_go && wst[0]) begin
      case (widx)
        IDX_RX_SRC: src_nxt = wd8;
        IDX_RX_SUP: sup_nxt = wd8;
        IDX_CTL_TWO: ctl2_nxt = wd8;
        IDX_IRQ_MASK: imask_nxt = wd[IRQ_W-1:0];
        default: src_nxt = src_r;
      endcase
    end
    if (wr_go && widx == IDX_CHBLK) begin
      for (int i = 0; i < 4; i++) begin
        if (wst[i]) begin
          chblk_nxt[8*i +: 8] = wd[8*i +: 8];
        end
      end
    end
    // a new event wins over a clear in the same cycle
    ist_nxt = (ist_r & ~w1c) | evt;
    udr_nxt = udr_evt || (udr_r && !stat_rd);
    abort_nxt = udr_evt;
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      src_r <= RST_SRC;
      sup_r <= RST_SUP;
      ctl2_r <= RST_CTL_TWO;
      chblk_r <= RST_CHBLK;
      imask_r <= RST_MASK;
      ist_r <= '0;
      udr_r <= 1'b0;
      abort_r <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      src_r <= src_nxt;
      sup_r <= sup_nxt;
      ctl2_r <= ctl2_nxt;
      chblk_r <= chblk_nxt;
      imask_r <= imask_nxt;
      ist_r <= ist_nxt;
      udr_r <= udr_nxt;
      abort_r <= abort_nxt;
      tx_empty_q <= tx_empty;
    end
  end

  assign TX_ABORT = abort_r;
  assign IRQ = |(ist_r & imask_r);

  // ==========================================
  // axi4-lite read channel
  logic rvalid_r, rvalid_nxt, ar_fire, rhit;
  logic [31:0] rdata_r, rdata_nxt, rmux;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] ridx;
  assign ARREADY = !rvalid_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign ar_fire = ARVALID && ARREADY;
  assign ridx = ARADDR[9:2];
  assign stat_rd = ar_fire && (ridx == IDX_TX_STAT);
  assign rx_pop = ar_fire && (ridx == IDX_RX_PORT) && !rx_empty;
  always_comb begin
    rmux = 32'h0;
    rhit = 1'b1;
    case (ridx)
      IDX_RX_INFO: rmux[RX_EMPTY_BIT] = rx_empty;
      IDX_RX_PORT: rmux[7:0] = rx_empty ? 8'h00 : rx_head;
      IDX_TX_STAT: begin
        // upper bits read zero, host must not rely on them
        rmux[TX_EMPTY_BIT] = tx_empty;
        rmux[TX_FULL_BIT] = tx_full;
        rmux[TX_UDR_BIT] = udr_r;
      end
      IDX_TX_PORT: rmux = 32'h0;
      IDX_RX_SRC: rmux[7:0] = src_r;
      IDX_RX_SUP: rmux[7:0] = sup_r;
      IDX_CTL_TWO: rmux[7:0] = ctl2_r;
      IDX_CHBLK: rmux = chblk_r;
      IDX_IRQ_STAT: rmux[IRQ_W-1:0] = ist_r;
      IDX_IRQ_MASK: rmux[IRQ_W-1:0] = imask_r;
      default: rhit = 1'b0;
    endcase
    rvalid_nxt = ar_fire || (rvalid_r && !RREADY);
    rdata_nxt = ar_fire ? rmux : rdata_r;
    rresp_nxt = ar_fire ? (rhit ? RESP_OKAY : RESP_SLVERR) : rresp_r;
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ==========================================
  // receive source and channel selection
  logic [7:0] hd_r, hd_nxt, hen_r, hen_nxt;
  logic hstb_r, hstb_nxt, use_ds0, sa_slot;
  logic [CH_W-1:0] sa_sel, chan;
  // legacy sa choice unless the override hands control over
  assign sa_sel = src_r[SRC_OVR_BIT] ? src_r[CH_W-1:0] : ctl2_r[CTL_TWO_SA_LSB +: CH_W];
  assign use_ds0 = src_r[SRC_OVR_BIT] && src_r[SA_DS0_BIT];
  assign chan = src_r[CH_W-1:0];
  assign sa_slot = (RX_TS_NUM == SA_TS) && RX_TS_NFAS;
  always_comb begin
    hstb_nxt = RX_TS_STB;
    hd_nxt = hd_r;
    hen_nxt = hen_r;
    if (RX_TS_STB) begin
      hd_nxt = RX_TS_DATA;
      hen_nxt = 8'h00;
      if (!use_ds0) begin
        if (sa_slot) begin
          hen_nxt = {3'h0, sa_sel};
        end
      end else if (src_r[MODE_BIT]) begin
        if (chblk_r[RX_TS_NUM]) begin
          hen_nxt = ~sup_r;
        end
      end else if (RX_TS_NUM == chan) begin
        hen_nxt = ~sup_r;
      end
    end
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hd_r <= 8'h00;
      hen_r <= 8'h00;
      hstb_r <= 1'b0;
    end else begin
      hd_r <= hd_nxt;
      hen_r <= hen_nxt;
      hstb_r <= hstb_nxt;
    end
  end

  assign RX_HDLC_DATA = hd_r;
  assign RX_HDLC_EN = hen_r;
  assign RX_HDLC_STB = hstb_r;

  // ==========================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  sequence s_stat_rd;
    ARVALID && ARREADY && ARADDR[9:2] == IDX_TX_STAT;
  endsequence
  property p_tx_empty;
    s_stat_rd |=> RDATA[TX_EMPTY_BIT] == $past(tx_empty) && RVALID;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("empty bit wrong");
  property p_tx_full;
    s_stat_rd |=> RDATA[TX_FULL_BIT] == $past(tx_full) && RDATA[7:3] == 5'h0;
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("full bit wrong");
  property p_abort;
    TX_FIFO_RREADY && !TX_FIFO_RVALID && TX_IN_MSG |=> TX_ABORT && udr_r;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort on underrun");
  property p_udr_clear;
    s_stat_rd ##0 !udr_evt |=> !udr_r ##1 (RDATA[TX_UDR_BIT] == $past(udr_r, 2));
  endproperty
  a_udr_clear: assert property (p_udr_clear) else $error("underrun not cleared");
  property p_udr_hold;
    udr_r && !(ARVALID && ARREADY && ARADDR[9:2] == IDX_TX_STAT) |=> udr_r;
  endproperty
  a_udr_hold: assert property (p_udr_hold) else $error("underrun lost");
  sequence s_sa_slot;
    RX_TS_STB && !use_ds0 && RX_TS_NUM == SA_TS && RX_TS_NFAS;
  endsequence
  property p_sa_route;
    s_sa_slot |=> RX_HDLC_STB && RX_HDLC_EN == {3'h0, $past(sa_sel)};
  endproperty
  a_sa_route: assert property (p_sa_route) else $error("sa enable wrong");
  property p_legacy;
    s_sa_slot ##0 !src_r[SRC_OVR_BIT] |=>
      RX_HDLC_EN[4:0] == $past(ctl2_r[CTL_TWO_SA_LSB +: CH_W]);
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy sa wrong");
  property p_one_chan;
    RX_TS_STB && use_ds0 && !src_r[MODE_BIT] |=>
      RX_HDLC_EN == ($past(RX_TS_NUM == chan) ? ~$past(sup_r) : 8'h00);
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("channel pick wrong");
  property p_blk_chan;
    RX_TS_STB && use_ds0 && src_r[MODE_BIT] |=>
      RX_HDLC_EN == ($past(chblk_r[RX_TS_NUM]) ? ~$past(sup_r) : 8'h00);
  endproperty
  a_blk_chan: assert property (p_blk_chan) else $error("block pick wrong");
  property p_rx_pop;
    ARVALID && ARREADY && ARADDR[9:2] == IDX_RX_PORT && !rx_empty |=>
      RDATA[7:0] == $past(rx_head);
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx port data wrong");
  property p_rx_empty;
    ARVALID && ARREADY && ARADDR[9:2] == IDX_RX_INFO |=>
      RDATA[RX_EMPTY_BIT] == $past(rx_empty);
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("rx empty wrong");
endmodule

// ---- verification/hfcs_partner.sv ----
`timescale 1ns/1ns
// ==========================================
// framer timeslot source and hdlc engine stand-in
module hfcs_partner (
  // clock
  input wire logic clk,
  // timeslot stream
  output logic [7:0] ts_data,
  output logic [hfcs_pkg::CH_W-1:0] ts_num,
  output logic ts_nfas,
  output logic ts_stb,
  // receive engine bytes
  output logic [7:0] rx_wdata,
  output logic rx_wvalid,
  input wire logic rx_wready,
  // transmit engine drain
  input wire logic [7:0] tx_rdata,
  input wire logic tx_rvalid,
  output logic tx_rready,
  output logic tx_in_msg,
  input wire logic tx_abort
);
  initial begin
    {ts_data, ts_num, ts_nfas, ts_stb} = '0;
    {rx_wdata, rx_wvalid, tx_rready, tx_in_msg} = '0;
  end
  // data lines flip once the strobe drops so stale values never look valid
  task automatic send_ts(input logic [7:0] d, input logic [4:0] n, input logic f);
    @(posedge clk);
    ts_data <= d;
    ts_num <= n;
    ts_nfas <= f;
    ts_stb <= 1'b1;
    @(posedge clk);
    ts_stb <= 1'b0;
    ts_data <= ~d;
  endtask
  task automatic push_rx(input logic [7:0] b);
    @(posedge clk);
    rx_wdata <= b;
    rx_wvalid <= 1'b1;
    do @(negedge clk); while (rx_wready !== 1'b1);
    @(posedge clk);
    rx_wvalid <= 1'b0;
    rx_wdata <= ~b;
  endtask
  task automatic pop_tx(output logic [7:0] b);
    @(posedge clk);
    tx_rready <= 1'b1;
    do @(negedge clk); while (tx_rvalid !== 1'b1);
    b = tx_rdata;
    @(posedge clk);
    tx_rready <= 1'b0;
  endtask
  // pulls one byte mid-message from an empty fifo, then drops the message
  task automatic underrun(output logic ab);
    @(posedge clk);
    tx_in_msg <= 1'b1;
    tx_rready <= 1'b1;
    @(posedge clk);
    tx_in_msg <= 1'b0;
    tx_rready <= 1'b0;
    #1 ab = tx_abort;
  endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
  import hfcs_pkg::*;
  localparam int D = 4;
  logic MCLK, ARST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, IRQ, TX_ABORT;
  logic [9:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [7:0] TSD, HD, HE, RWD, TRD;
  logic [4:0] TSN;
  logic TSF, TSS, HS, RWV, RWR, TRV, TRR, TIM;
  logic [31:0] v;
  logic [7:0] b;
  logic ab;
  int fails, checks;
  hfcs_top #(.DEPTH(D)) hfcs_top_inst (.MCLK(MCLK), .ARST_N(ARST_N),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .RX_TS_DATA(TSD), .RX_TS_NUM(TSN), .RX_TS_NFAS(TSF),
    .RX_TS_STB(TSS), .RX_HDLC_DATA(HD), .RX_HDLC_EN(HE), .RX_HDLC_STB(HS),
    .RX_FIFO_WDATA(RWD), .RX_FIFO_WVALID(RWV), .RX_FIFO_WREADY(RWR), .TX_FIFO_RDATA(TRD),
    .TX_FIFO_RVALID(TRV), .TX_FIFO_RREADY(TRR), .TX_IN_MSG(TIM), .TX_ABORT(TX_ABORT),
    .IRQ(IRQ));
  hfcs_partner hfcs_partner_inst (.clk(MCLK), .ts_data(TSD), .ts_num(TSN), .ts_nfas(TSF),
    .ts_stb(TSS), .rx_wdata(RWD), .rx_wvalid(RWV), .rx_wready(RWR), .tx_rdata(TRD),
    .tx_rvalid(TRV), .tx_rready(TRR), .tx_in_msg(TIM), .tx_abort(TX_ABORT));
  // ==========================================
  // clock, reset, watchdog
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  initial begin
    #400000;
    fails++;
    test_done();
  end
  // ==========================================
  // compare and bus tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s response expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    bit a, w, ra, rw;
    a = 0;
    w = 0;
    @(posedge MCLK);
    AWADDR <= {idx, 2'b00};
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(a && w)) begin
      @(negedge MCLK);
      ra = AWREADY;
      rw = WREADY;
      @(posedge MCLK);
      if (ra && !a) begin
        a = 1;
        AWVALID <= 1'b0;
      end
      if (rw && !w) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    do @(negedge MCLK); while (BVALID !== 1'b1);
    chk_resp("bresp", er, BRESP);
    @(posedge MCLK);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er);
    @(posedge MCLK);
    ARADDR <= {idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(negedge MCLK); while (ARREADY !== 1'b1);
    @(posedge MCLK);
    ARVALID <= 1'b0;
    do @(negedge MCLK); while (RVALID !== 1'b1);
    d = RDATA;
    chk_resp("rresp", er, RRESP);
    @(posedge MCLK);
    RREADY <= 1'b0;
  endtask
  // masked view of tx status; bits 7 to 3 carry no meaning
  task automatic tx_stat(input logic [2:0] e);
    rd(IDX_TX_STAT, v, RESP_OKAY);
    chk("tx status", {29'h0, e}, {29'h0, v[2:0]});
  endtask
  task automatic route(input logic [7:0] c, input logic [7:0] s, input logic [4:0] n,
                       input logic f, input logic [7:0] e);
    wr(IDX_RX_SRC, {24'h0, c}, RESP_OKAY);
    wr(IDX_RX_SUP, {24'h0, s}, RESP_OKAY);
    hfcs_partner_inst.send_ts(8'h5a ^ {3'h0, n}, n, f);
    #1;
    chk("hdlc strobe", 32'h1, {31'h0, HS});
    chk("hdlc data", {24'h0, 8'h5a ^ {3'h0, n}}, {24'h0, HD});
    chk("hdlc enables", {24'h0, e}, {24'h0, HE});
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    {AWADDR, AWVALID, WDATA, WVALID, BREADY, ARADDR, ARVALID, RREADY} = '0;
    WSTRB = 4'hf;
    ARST_N = 1'b0;
    repeat (12) @(posedge MCLK);
    ARST_N <= 1'b1;
    rd(IDX_RX_SRC, v, RESP_OKAY);
    chk("source reset", 32'h0, v);
    rd(IDX_RX_SUP, v, RESP_OKAY);
    chk("suppress reset", 32'h0, v);
    rd(8'h10, v, RESP_SLVERR);
    wr(8'h10, 32'hff, RESP_SLVERR);
    rd(IDX_RX_INFO, v, RESP_OKAY);
    chk("rx empty", 32'h1, {31'h0, v[RX_EMPTY_BIT]});
    tx_stat(3'b100);
    wr(IDX_RX_SUP, 32'h0000_00c3, RESP_OKAY);
    rd(IDX_RX_SUP, v, RESP_OKAY);
    chk("suppress rw", 32'hc3, v);
    // transmit fifo filled past full, then drained in order
    for (int i = 0; i <= D; i++) wr(IDX_TX_PORT, 32'h80 | i, RESP_OKAY);
    tx_stat(3'b010);
    for (int i = 0; i < D; i++) begin
      hfcs_partner_inst.pop_tx(b);
      chk("tx byte", 32'h80 | i, {24'h0, b});
    end
    tx_stat(3'b100);
    chk("tx valid", 32'h0, {31'h0, TRV});
    rd(IDX_IRQ_STAT, v, RESP_OKAY);
    chk("irq status tx empty", 32'h4, v);
    // underrun, latch, clear on read, interrupt mask and clear
    wr(IDX_IRQ_STAT, 32'h7, RESP_OKAY);
    hfcs_partner_inst.underrun(ab);
    chk("abort", 32'h1, {31'h0, ab});
    #1 chk("irq masked", 32'h0, {31'h0, IRQ});
    wr(IDX_IRQ_MASK, 32'h1, RESP_OKAY);
    #1 chk("irq on", 32'h1, {31'h0, IRQ});
    tx_stat(3'b101);
    tx_stat(3'b100);
    wr(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    #1 chk("irq cleared", 32'h0, {31'h0, IRQ});
    // receive fifo filled until refused, then drained
    for (int i = 0; i < D; i++) hfcs_partner_inst.push_rx(8'h81 ^ (i << 3));
    #1 chk("rx refuses", 32'h0, {31'h0, RWR});
    rd(IDX_IRQ_STAT, v, RESP_OKAY);
    chk("irq status rx byte", 32'h2, v);
    rd(IDX_IRQ_MASK, v, RESP_OKAY);
    chk("irq mask", 32'h1, v);
    chk("irq masked rx", 32'h0, {31'h0, IRQ});
    rd(IDX_RX_INFO, v, RESP_OKAY);
    chk("rx not empty", 32'h0, {31'h0, v[RX_EMPTY_BIT]});
    for (int i = 0; i < D; i++) begin
      rd(IDX_RX_PORT, v, RESP_OKAY);
      chk("rx byte", 32'h81 ^ (i << 3), v);
    end
    rd(IDX_RX_INFO, v, RESP_OKAY);
    chk("rx empty again", 32'h1, {31'h0, v[RX_EMPTY_BIT]});
    rd(IDX_RX_PORT, v, RESP_OKAY);
    chk("rx empty read", 32'h0, v);
    // receive routing
    wr(IDX_CTL_TWO, 32'ha0, RESP_OKAY);
    wr(IDX_CHBLK, 32'h0000_0104, RESP_OKAY);
    route(8'h00, 8'h00, 5'd0, 1'b1, 8'h14);
    route(8'h00, 8'h00, 5'd0, 1'b0, 8'h00);
    route(8'h83, 8'h00, 5'd0, 1'b1, 8'h03);
    route(8'h83, 8'h00, 5'd1, 1'b1, 8'h00);
    route(8'hc5, 8'h81, 5'd5, 1'b0, 8'h7e);
    route(8'hc5, 8'h81, 5'd20, 1'b0, 8'h00);
    route(8'hd4, 8'h00, 5'd20, 1'b0, 8'hff);
    route(8'he0, 8'h0f, 5'd8, 1'b0, 8'hf0);
    route(8'he0, 8'h00, 5'd5, 1'b0, 8'h00);
    test_done();
  end
endmodule
